// ===== verilog/iss_indicator_top.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
//Contract
// - Each of the four indicators takes its source from its own 4-bit field of one register.
// - The general-purpose indicator field sits in bits 15:12, is read-write and resets to 0110.
// - The third indicator field sits in bits 11:8, is read-write and resets to 0001.
// - The second indicator field sits in bits 7:4, is read-write and resets to 0101.
// - The first indicator field sits in bits 3:0, is read-write and resets to 0000.
// - Code 0000 lights the indicator whenever a link is up, at any speed.
// - Code 0001 follows receive or transmit activity and code 0010 transmit activity only.
// - Code 1011 lights on link and blinks while transmit or receive activity occurs.
// - Code 1010 follows full duplex and code 1001 a 100 or 1000 megabit link.
// - Code 1000 follows a 10 or 100 megabit link and code 0111 a 10 megabit link only.
// - Code 0110 follows a 100 megabit twisted-pair link.
// - Code 1110 follows a receive error and code 1101 a receive or transmit error.
// - Each output has a polarity bit resetting to one for active high; zero makes it low.
// - A set drive-enable bit forces the output from its drive-value bit instead of the source.
module iss_indicator_top #(
    parameter int unsigned BLINK_CYCLES = iss_pkg::BLINK_CYCLES_DEF
) (
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [iss_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [iss_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    input  wire iss_pkg::iss_phy_s            phy_status,
    output logic [iss_pkg::NUM_IND-1:0]       indicator_output
);
    import iss_pkg::*;

    // ************************************************************
    // Declarations.
    // ************************************************************
    logic [15:0]            indicator_source_map_q;
    logic [15:0]            drive_ctrl_q;
    logic [ADDR_W-1:0]      wr_addr_q;
    logic [31:0]            wr_data_q;
    logic [3:0]             wr_strb_q;
    logic                   aw_held_q;
    logic                   w_held_q;
    iss_bus_e               wr_state_q;
    iss_bus_e               rd_state_q;
    logic                   wr_fire;
    logic                   wr_hit_src;
    logic                   wr_hit_drv;
    logic [15:0]            src_wmask;
    logic [15:0]            drv_wmask;
    logic [31:0]            rd_word;
    logic                   rd_hit;
    iss_phy_s               phy_sync;
    logic [31:0]            blink_cnt_q;
    logic                   blink_tick;
    logic                   blink_phase_q;
    logic [NUM_IND-1:0]     src_active;
    logic [NUM_IND-1:0]     ind_level;

    // ************************************************************
    // Helper functions.
    // ************************************************************

    // Expands the two low byte strobes into a mask over a 16-bit register.
    function automatic logic [15:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    // Word-aligned address compare; the two low address bits are ignored.
    function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                     input logic [7:0]        offset);
        addr_is = (addr[ADDR_W-1:2] == offset[ADDR_W-1:2]);
    endfunction : addr_is

    // ************************************************************
    // Write address and write data capture.
    // ************************************************************

    // The address is held until the data also arrive, so either may come first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            wr_addr_q     <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                wr_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            // Ready drops for the cycle after a take so no second address slips in.
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready)
                             && (wr_state_q == BUS_IDLE);
        end
    end

    // Same scheme for the data channel, independent of the address channel.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q     <= 1'b0;
            wr_data_q    <= '0;
            wr_strb_q    <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q  <= 1'b1;
                wr_data_q <= s_axi_wdata;
                wr_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
            s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready)
                            && (wr_state_q == BUS_IDLE);
        end
    end

    // A write commits once both halves are held and no response is pending.
    assign wr_fire    = aw_held_q && w_held_q && (wr_state_q == BUS_IDLE);
    assign wr_hit_src = addr_is(wr_addr_q, SRC_MAP_OFFSET);
    assign wr_hit_drv = addr_is(wr_addr_q, DRIVE_CTRL_OFFSET);
    assign src_wmask  = lane_mask(wr_strb_q);
    assign drv_wmask  = lane_mask(wr_strb_q) & DRIVE_CTRL_MASK;

    // ************************************************************
    // Write response.
    // ************************************************************

    // Unmapped or read-only targets answer SLVERR and change nothing.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q   <= BUS_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            case (wr_state_q)
                BUS_IDLE: begin
                    if (wr_fire) begin
                        wr_state_q   <= BUS_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= (wr_hit_src || wr_hit_drv) ? RESP_OKAY
                                                                   : RESP_SLVERR;
                    end
                end
                BUS_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_q   <= BUS_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state_q   <= BUS_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Control registers.
    // ************************************************************

    // Source map: all four fields are plain read-write with their own reset codes.
    // Reserved codes are stored as written; the selector keeps such an output off.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            indicator_source_map_q <= SRC_MAP_RESET;
        end else if (wr_fire && wr_hit_src) begin
            indicator_source_map_q <= (indicator_source_map_q & ~src_wmask)
                                    | (wr_data_q[15:0] & src_wmask);
        end
    end

    // Drive control: per indicator a force enable, a force value and a polarity.
    // The top bit of each nibble is reserved, ignores writes and reads zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_ctrl_q <= DRIVE_CTRL_RESET;
        end else if (wr_fire && wr_hit_drv) begin
            drive_ctrl_q <= (drive_ctrl_q & ~drv_wmask) | (wr_data_q[15:0] & drv_wmask);
        end
    end

    // ************************************************************
    // Read channel.
    // ************************************************************

    // Status word shows the outputs and the synchronised conditions.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (addr_is(s_axi_araddr, SRC_MAP_OFFSET)) begin
            rd_word[15:0] = indicator_source_map_q;
        end else if (addr_is(s_axi_araddr, DRIVE_CTRL_OFFSET)) begin
            rd_word[15:0] = drive_ctrl_q;
        end else if (addr_is(s_axi_araddr, STATUS_OFFSET)) begin
            rd_word[NUM_IND-1:0]              = indicator_output;
            rd_word[8 +: PHY_W]               = phy_sync;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Address is taken and data returned one cycle later; one read at a time.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q    <= BUS_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            case (rd_state_q)
                BUS_IDLE: begin
                    s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
                    if (s_axi_arvalid && s_axi_arready) begin
                        rd_state_q   <= BUS_RESP;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata  <= rd_word;
                        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                BUS_RESP: begin
                    s_axi_arready <= 1'b0;
                    if (s_axi_rready) begin
                        rd_state_q    <= BUS_IDLE;
                        s_axi_rvalid  <= 1'b0;
                        s_axi_arready <= 1'b1;
                    end
                end
                default: begin
                    rd_state_q    <= BUS_IDLE;
                    s_axi_rvalid  <= 1'b0;
                    s_axi_arready <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Condition inputs.
    // ************************************************************

    // Conditions come from the line side, so they are synchronised first.
    iss_sync #(
        .WIDTH    (PHY_W)
    ) u_phy_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (phy_status),
        .sync_out (phy_sync)
    );

    // ************************************************************
    // Blink timebase.
    // ************************************************************

    // A single divider serves all indicators, so they blink in step.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt_q <= '0;
        end else if (blink_tick) begin
            blink_cnt_q <= '0;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
        end
    end

    assign blink_tick = (blink_cnt_q >= BLINK_CYCLES - 1);

    // Phase flips on each enable pulse; activity gates the link light with it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_phase_q <= 1'b0;
        end else if (blink_tick) begin
            blink_phase_q <= ~blink_phase_q;
        end
    end

    // ************************************************************
    // Per-indicator source selection and output stage.
    // ************************************************************
    generate
        for (genvar i = 0; i < NUM_IND; i++) begin : g_ind
            // Each output reads only its own field of the source map.
            iss_src_mux u_mux (
                .code        (indicator_source_map_q[i*FIELD_W +: FIELD_W]),
                .phy         (phy_sync),
                .blink_phase (blink_phase_q),
                .active      (src_active[i])
            );

            // Forcing replaces the source; polarity then sets the pin level.
            always_comb begin
                if (drive_ctrl_q[i*FIELD_W + FORCE_EN_BIT]) begin
                    ind_level[i] = drive_ctrl_q[i*FIELD_W + FORCE_VAL_BIT];
                end else begin
                    ind_level[i] = src_active[i];
                end
            end

            // Registered so every pin is glitch-free and comes from a flop.
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    indicator_output[i] <= 1'b0;
                end else begin
                    indicator_output[i] <= ~(ind_level[i]
                                          ^ drive_ctrl_q[i*FIELD_W + POLARITY_BIT]);
                end
            end
        end
    endgenerate

endmodule : iss_indicator_top

// ===== verilog/iss_pkg.sv
package iss_pkg;

    // ************************************************************
    // Register map and field layout.
    // ************************************************************
    localparam int unsigned ADDR_W              = 8;
    localparam logic [7:0]  SRC_MAP_OFFSET      = 8'h18;
    localparam logic [7:0]  DRIVE_CTRL_OFFSET   = 8'h1C;
    localparam logic [7:0]  STATUS_OFFSET       = 8'h20;
    localparam logic [15:0] SRC_MAP_RESET       = 16'h6150;
    localparam logic [15:0] DRIVE_CTRL_RESET    = 16'h4444;
    localparam logic [15:0] DRIVE_CTRL_MASK     = 16'h7777;
    localparam int unsigned NUM_IND             = 4;
    localparam int unsigned FIELD_W             = 4;
    localparam int unsigned FORCE_EN_BIT        = 0;
    localparam int unsigned FORCE_VAL_BIT       = 1;
    localparam int unsigned POLARITY_BIT        = 2;
    localparam logic [1:0]  RESP_OKAY           = 2'h0;
    localparam logic [1:0]  RESP_SLVERR         = 2'h2;

    // ************************************************************
    // Timing of the blink phase for the link-and-activity source.
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS       = 5;
    localparam int unsigned BLINK_HALF_NS       = 50000000;
    localparam int unsigned BLINK_CYCLES_DEF    = BLINK_HALF_NS / CLK_PERIOD_NS;

    // ************************************************************
    // Source codes, speed codes and state types.
    // ************************************************************
    typedef enum logic [3:0] {
        SRC_LINK        = 4'h0,
        SRC_RX_OR_TX    = 4'h1,
        SRC_TX_ACT      = 4'h2,
        SRC_RX_ACT      = 4'h3,
        SRC_COLLISION   = 4'h4,
        SRC_LINK_1000   = 4'h5,
        SRC_LINK_100TX  = 4'h6,
        SRC_LINK_10     = 4'h7,
        SRC_LINK_10_100 = 4'h8,
        SRC_LINK_100_1G = 4'h9,
        SRC_FULL_DUPLEX = 4'hA,
        SRC_LINK_BLINK  = 4'hB,
        SRC_RSVD_C      = 4'hC,
        SRC_RX_OR_TX_ER = 4'hD,
        SRC_RX_ER       = 4'hE,
        SRC_RSVD_F      = 4'hF
    } iss_src_e;

    localparam logic [1:0] SPEED_10   = 2'h0;
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_RESP = 1'b1
    } iss_bus_e;

    // Physical-layer conditions that feed the indicators.
    typedef struct packed {
        logic       link_up;
        logic [1:0] speed;
        logic       full_duplex;
        logic       tx_active;
        logic       rx_active;
        logic       tx_error;
        logic       rx_error;
        logic       collision;
    } iss_phy_s;

    localparam int unsigned PHY_W = $bits(iss_phy_s);

endpackage : iss_pkg

// ===== verilog/iss_sync.sv
`timescale 1ns/1ps
module iss_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // Two flops per bit; only the second stage is ever read.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : iss_sync

// ===== verilog/iss_src_mux.sv
`timescale 1ns/1ps
module iss_src_mux (
    input  wire logic             [3:0] code,
    input  wire iss_pkg::iss_phy_s      phy,
    input  wire logic                   blink_phase,
    output logic                        active
);
    import iss_pkg::*;

    logic link_act;

    assign link_act = phy.tx_active | phy.rx_active;

    // One condition per source code; reserved codes keep the indicator off.
    always_comb begin
        case (iss_src_e'(code))
            SRC_LINK:        active = phy.link_up;
            SRC_RX_OR_TX:    active = link_act;
            SRC_TX_ACT:      active = phy.tx_active;
            SRC_RX_ACT:      active = phy.rx_active;
            SRC_COLLISION:   active = phy.collision;
            SRC_LINK_1000:   active = phy.link_up & (phy.speed == SPEED_1000);
            SRC_LINK_100TX:  active = phy.link_up & (phy.speed == SPEED_100);
            SRC_LINK_10:     active = phy.link_up & (phy.speed == SPEED_10);
            SRC_LINK_10_100: active = phy.link_up & (phy.speed != SPEED_1000);
            SRC_LINK_100_1G: active = phy.link_up & (phy.speed != SPEED_10);
            SRC_FULL_DUPLEX: active = phy.full_duplex;
            SRC_LINK_BLINK:  active = phy.link_up & ~(link_act & blink_phase);
            SRC_RX_OR_TX_ER: active = phy.rx_error | phy.tx_error;
            SRC_RX_ER:       active = phy.rx_error;
            default:         active = 1'b0;
        endcase
    end

endmodule : iss_src_mux

// ===== bench/iss_indicator_monitor.sv
`timescale 1ns/1ps
module iss_indicator_monitor
    import iss_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire iss_phy_s          phy_status,
    input wire logic [3:0]        indicator_output
);
    // ********************
    // Bus and output checks.
    // ********************
    default clocking cb @(posedge aclk);
    endclocking

    // Hand-offs on the two request channels.
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // Only the three register words answer OKAY; anything else must fail loudly.
    logic rd_mapped;
    assign rd_mapped = (s_axi_araddr == SRC_MAP_OFFSET) || (s_axi_araddr == DRIVE_CTRL_OFFSET)
                    || (s_axi_araddr == STATUS_OFFSET);

    chk_write_answer: assert property (disable iff (!aresetn) wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (disable iff (!aresetn) rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read response missing");
    chk_bresp_hold: assert property (disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (disable iff (!aresetn) s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped early");
    chk_write_blocked: assert property (disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_read_blocked: assert property (disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while response pending");
    chk_unmapped_read: assert property (disable iff (!aresetn) rd_taken and !rd_mapped
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
    chk_reset_quiet: assert property (!aresetn
        |=> indicator_output == 4'h0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active in reset");
endmodule : iss_indicator_monitor

bind iss_indicator_top iss_indicator_monitor mon (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .phy_status, .indicator_output
);

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import iss_pkg::*;
    // ********************
    // Signals and the case table.
    // ********************
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, indicator_output;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, seen;
    iss_phy_s    phy_status;
    int          num_errors, comparisons;
    // Row: source code, condition vector, expected lit level; reserved codes stay unused.
    logic [13:0] rows [0:31] = '{{4'h0, 9'h100, 1'b1}, {4'h0, 9'h000, 1'b0},
        {4'h0, 9'h180, 1'b1}, {4'h1, 9'h008, 1'b1}, {4'h1, 9'h010, 1'b1}, {4'h1, 9'h000, 1'b0},
        {4'h2, 9'h010, 1'b1}, {4'h2, 9'h008, 1'b0}, {4'h3, 9'h008, 1'b1}, {4'h3, 9'h010, 1'b0},
        {4'h4, 9'h001, 1'b1}, {4'h4, 9'h000, 1'b0}, {4'h5, 9'h180, 1'b1}, {4'h5, 9'h140, 1'b0},
        {4'h6, 9'h140, 1'b1}, {4'h6, 9'h100, 1'b0}, {4'h6, 9'h040, 1'b0}, {4'h7, 9'h100, 1'b1},
        {4'h7, 9'h140, 1'b0}, {4'h8, 9'h140, 1'b1}, {4'h8, 9'h180, 1'b0}, {4'h9, 9'h180, 1'b1},
        {4'h9, 9'h100, 1'b0}, {4'hA, 9'h020, 1'b1}, {4'hA, 9'h000, 1'b0}, {4'hB, 9'h100, 1'b1},
        {4'hB, 9'h000, 1'b0}, {4'hD, 9'h004, 1'b1}, {4'hD, 9'h002, 1'b1}, {4'hD, 9'h000, 1'b0},
        {4'hE, 9'h002, 1'b1}, {4'hE, 9'h004, 1'b0}};

    iss_indicator_top #(.BLINK_CYCLES(4)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .phy_status, .indicator_output
    );

    // ********************
    // Clock, watchdog and shared tasks.
    // ********************
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // The whole run needs under two thousand cycles, so this only fires on a hang.
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        test_done();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // The response ready is raised late on purpose so the slave must hold its answer.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er), "bresp");
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rdr

    task automatic settle();
        repeat (4) @(posedge aclk);
    endtask : settle

    task test_done();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    // ********************
    // Main sequence.
    // ********************
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        phy_status = '0;
        num_errors = 0;
        comparisons = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        phy_status <= 9'h148;
        repeat (2) @(posedge aclk);
        settle();
        chk(32'(indicator_output), 32'hD, "reset map outputs");
        rdr(SRC_MAP_OFFSET);
        chk(rd, 32'h6150, "map reset");
        rdr(DRIVE_CTRL_OFFSET);
        chk(rd, 32'h4444, "drive reset");
        wr(SRC_MAP_OFFSET, 32'hA987, RESP_OKAY);
        rdr(SRC_MAP_OFFSET);
        chk(rd, 32'hA987, "map readback");
        // Every non-reserved source code on all four indicators at once.
        foreach (rows[i]) begin
            wr(SRC_MAP_OFFSET, {16'h0, {4{rows[i][13:10]}}}, RESP_OKAY);
            phy_status <= rows[i][9:1];
            settle();
            chk(32'(indicator_output), 32'({4{rows[i][0]}}), "table");
        end
        // Inverted polarity, then forcing that overrides the selected source.
        wr(SRC_MAP_OFFSET, 32'h0, RESP_OKAY);
        phy_status <= 9'h140;
        wr(DRIVE_CTRL_OFFSET, 32'h0, RESP_OKAY);
        settle();
        chk(32'(indicator_output), 32'h0, "active low");
        phy_status <= 9'h000;
        wr(DRIVE_CTRL_OFFSET, 32'h3347, RESP_OKAY);
        settle();
        chk(32'(indicator_output), 32'h1, "forced, no link");
        phy_status <= 9'h140;
        settle();
        chk(32'(indicator_output), 32'h3, "forced, link");
        wr(DRIVE_CTRL_OFFSET, 32'h4444, RESP_OKAY);
        // An unmapped word is refused both ways and leaves the map alone.
        rdr(8'h04);
        chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
        wr(8'h04, 32'hFFFF, RESP_SLVERR);
        rdr(SRC_MAP_OFFSET);
        chk(rd, 32'h0, "map after bad write");
        // Link with traffic must show both levels within a few blink periods.
        wr(SRC_MAP_OFFSET, 32'hBBBB, RESP_OKAY);
        phy_status <= 9'h110;
        settle();
        seen = 2'b00;
        repeat (16) begin
            @(posedge aclk);
            seen[indicator_output[0]] = 1'b1;
        end
        chk(32'(seen), 32'h3, "blink");
        // A second reset in mid-run restores the defaults.
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(SRC_MAP_OFFSET);
        chk(rd, 32'h6150, "map after reset");
        test_done();
    end
endmodule : testbench
